// >>> rtl/mode_word_pkg.sv
// Purpose: constants, types and helpers for the mode-word and burst block
// Assumes: 50 MHz device clock, x8 organisation with A0-A13 on the address
// Notes: one beat pair per clock, as the data path moves two words a clock
//
// Contract
// - mode load only with cs, ras, cas, we and bank bits all low
// - reload allowed any time in normal operation when all banks precharged; the code also refuses a load during a burst or within tMRD of the last load
// - burst length field A0-A2: 010 gives four beats, 011 eight
// - A3 selects burst order: low sequential, high interleaved
// - CAS latency field A4-A6: codes 3 to 7 clocks, lower codes reserved
// - only whole-clock CAS latencies, no half-cycle setting
// - A8 high resets the DLL, low leaves it alone
// - write recovery field A9-A11: codes 1 to 7 give 2 to 8 clocks
// - A12 selects power-down exit speed: low fast, high slow
// - write recovery plus precharge period delay auto-precharge after write
// - four-beat: sequential counts up modulo four, interleave xors low bits
// - eight-beat sequential wraps low bits inside each group of four
// - eight-beat interleaved beat address is start xor beat index
// - same-kind commands one burst apart stream with no gap
// - burst-terminate encoding has no meaning to the device
// - mode load and DLL reset leave the array contents unchanged
`default_nettype none
package mode_word_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int TRP_NS = 15;
  localparam int TRP_CYC_RAW = (TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRP_CYC = (TRP_CYC_RAW < 1) ? 1 : TRP_CYC_RAW;
  localparam logic [4:0] TRP_CYC_W = 5'(TRP_CYC);
  localparam logic [2:0] TMRD_CYC = 3'h2;
  localparam logic [7:0] DLL_LOCK_CYC = 8'hC8;

  // organisation
  localparam logic ORG_X8 = 1'b1;
  localparam int ADDR_W = 14;

  // mode word field positions
  localparam int BL_LSB = 0;
  localparam int BT_BIT = 3;
  localparam int CL_LSB = 4;
  localparam int TM_BIT = 7;
  localparam int DLL_BIT = 8;
  localparam int WR_LSB = 9;
  localparam int PD_BIT = 12;
  localparam int A13_BIT = 13;
  localparam int AP_BIT = 10;

  // field codes and reset values
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] CL_CODE_MIN = 3'h3;
  localparam logic [2:0] WR_CODE_RSVD = 3'h0;
  localparam logic [13:0] MODE_RESET = 14'h0000;
  localparam logic [1:0] LAST_PAIR_4 = 2'h1;
  localparam logic [1:0] LAST_PAIR_8 = 2'h3;

  // command encodings {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_LOAD = 4'h0;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_TERM = 4'h6;
  localparam logic [2:0] BA_MODE = 3'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } burst_state_t;

  // column of one beat given start column and beat index
  function automatic logic [2:0] beat_col(input logic [2:0] start,
                                          input logic [2:0] idx,
                                          input logic len8,
                                          input logic il);
    logic [2:0] col;
    col = 3'h0;
    if (il) begin
      col = start ^ {idx[2] & len8, idx[1:0]};
    end else begin
      col[1:0] = 2'(start[1:0] + idx[1:0]);
      col[2] = start[2] ^ (idx[2] & len8);
    end
    return col;
  endfunction

endpackage
`default_nettype wire

// >>> rtl/burst_col_gen.sv
// Purpose: column order of the two beats moved in one clock of a burst
// Assumes: pair index counts clocks from the start of the burst
// Notes: purely combinational; the top registers the result
`timescale 1ns/10ps
`default_nettype none
module burst_col_gen
  import mode_word_pkg::*;
(
  input wire logic [2:0] start_col_i,
  input wire logic [1:0] pair_i,
  input wire logic len8_i,
  input wire logic interleave_i,
  output logic [2:0] col_a_o,
  output logic [2:0] col_b_o
);

  // even beat then odd beat of the current pair
  always_comb begin
    col_a_o = beat_col(start_col_i, {pair_i, 1'b0}, len8_i,
                       interleave_i);
    col_b_o = beat_col(start_col_i, {pair_i, 1'b1}, len8_i,
                       interleave_i);
  end

endmodule
`default_nettype wire

// >>> rtl/wr_recovery_timer.sv
// Purpose: delay from end of an auto-precharge write to bank precharged
// Assumes: one pending auto-precharge at a time
// Notes: a new start restarts the count; the older one is folded into it
`timescale 1ns/10ps
`default_nettype none
module wr_recovery_timer
  import mode_word_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [4:0] cycles_i,
  output logic busy_o,
  output logic done_o
);

  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic done_r;
  logic done_nxt;
  logic busy_r;
  logic busy_nxt;

  // count down the write recovery plus precharge span
  always_comb begin
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (start_i) begin
      cnt_nxt = cycles_i;
    end else if (cnt_r != 5'h00) begin
      cnt_nxt = 5'(cnt_r - 5'h01);
      done_nxt = (cnt_r == 5'h01);
    end
    // busy is registered so the port comes straight from a flop
    busy_nxt = (cnt_nxt != 5'h00);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 5'h00;
      done_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign busy_o = busy_r;
  assign done_o = done_r;

endmodule
`default_nettype wire

// >>> rtl/ddr2_mode_register_burst_order.sv
// Purpose: mode-word load, field decode and burst column ordering
// Assumes: bank state arrives from the bank logic as all_banks_idle_i
// Notes: one beat pair per clock; burst starts the clock after its command
`timescale 1ns/10ps
`default_nettype none
module ddr2_mode_register_burst_order
  import mode_word_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [2:0] ba_i,
  input wire logic [13:0] addr_i,
  input wire logic all_banks_idle_i,
  output logic [13:0] operating_mode_word_o,
  output logic mode_valid_o,
  output logic mode_busy_o,
  output logic burst_count_8_o,
  output logic burst_order_select_o,
  output logic [2:0] cas_latency_o,
  output logic factory_test_bit_o,
  output logic [3:0] wr_cycles_o,
  output logic powerdown_exit_speed_o,
  output logic mode_code_error_o,
  output logic dll_reset_o,
  output logic dll_ready_o,
  output logic burst_active_o,
  output logic burst_is_write_o,
  output logic [2:0] beat_col_a_o,
  output logic [2:0] beat_col_b_o,
  output logic cmd_error_o,
  output logic precharge_busy_o,
  output logic precharge_done_o
);

  // command decode
  logic [3:0] cmd;
  logic sel;
  logic is_load;
  logic is_read;
  logic is_write;
  logic [13:0] addr_m;

  // mode word state
  logic [13:0] mode_r;
  logic [13:0] mode_nxt;
  logic valid_r;
  logic valid_nxt;
  logic [3:0] wr_cyc_r;
  logic [3:0] wr_cyc_nxt;
  logic code_err_r;
  logic code_err_nxt;
  logic [2:0] mrd_cnt_r;
  logic [2:0] mrd_cnt_nxt;
  logic busy_r;
  logic busy_nxt;
  logic load_ok;
  logic bl8_r;
  logic bl8_nxt;

  // dll state
  logic dll_rst_r;
  logic dll_rst_nxt;
  logic [7:0] dll_cnt_r;
  logic [7:0] dll_cnt_nxt;
  logic dll_rdy_r;
  logic dll_rdy_nxt;

  // burst state
  burst_state_t state_r;
  burst_state_t state_nxt;
  logic [2:0] start_r;
  logic [2:0] start_nxt;
  logic [1:0] pair_r;
  logic [1:0] pair_nxt;
  logic len8_r;
  logic len8_nxt;
  logic il_r;
  logic il_nxt;
  logic ap_r;
  logic ap_nxt;
  logic [2:0] col_a_r;
  logic [2:0] col_b_r;
  logic [2:0] col_a_c;
  logic [2:0] col_b_c;
  logic err_r;
  logic err_nxt;
  logic last_pair;
  logic ap_start;
  logic [4:0] ap_cycles;
  logic tmr_busy;
  logic tmr_done;
  logic active_r;
  logic active_nxt;
  logic is_wr_r;
  logic is_wr_nxt;

  // the mode word lives at bank 0; other bank codes are extended registers
  always_comb begin
    cmd = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
    sel = cke_i;
    is_load = sel && (cmd == CMD_LOAD) && (ba_i == BA_MODE);
    is_read = sel && (cmd == CMD_READ);
    is_write = sel && (cmd == CMD_WRITE);
    // the terminate code is simply not decoded, so it acts as no operation
    addr_m = addr_i;
    if (!ORG_X8) begin
      addr_m[A13_BIT] = 1'b0;
    end
  end

  // a load counts only with banks precharged, no burst and tMRD elapsed
  assign load_ok = is_load && all_banks_idle_i && (state_r == ST_IDLE) &&
                   !busy_r;

  // mode word and decoded fields; a load replaces the whole word at once
  always_comb begin
    mode_nxt = mode_r;
    valid_nxt = valid_r;
    wr_cyc_nxt = wr_cyc_r;
    code_err_nxt = code_err_r;
    mrd_cnt_nxt = mrd_cnt_r;
    if (load_ok) begin
      mode_nxt = addr_m;
      valid_nxt = 1'b1;
      wr_cyc_nxt = 4'({1'b0, addr_m[WR_LSB +: 3]} + 4'h1);
      code_err_nxt =
        ((addr_m[BL_LSB +: 3] != BL_CODE_4) &&
         (addr_m[BL_LSB +: 3] != BL_CODE_8)) ||
        (addr_m[CL_LSB +: 3] < CL_CODE_MIN) ||
        (addr_m[WR_LSB +: 3] == WR_CODE_RSVD);
      mrd_cnt_nxt = TMRD_CYC;
    end else if (mrd_cnt_r != 3'h0) begin
      mrd_cnt_nxt = 3'(mrd_cnt_r - 3'h1);
    end
    busy_nxt = (mrd_cnt_nxt != 3'h0);
    // length flag kept in its own flop so the port needs no decode gate
    bl8_nxt = (mode_nxt[BL_LSB +: 3] == BL_CODE_8) && valid_nxt;
  end

  // the array is untouched here: only control registers are written
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_r <= MODE_RESET;
      valid_r <= 1'b0;
      wr_cyc_r <= 4'h0;
      code_err_r <= 1'b0;
      mrd_cnt_r <= 3'h0;
      busy_r <= 1'b0;
      bl8_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      valid_r <= valid_nxt;
      wr_cyc_r <= wr_cyc_nxt;
      code_err_r <= code_err_nxt;
      mrd_cnt_r <= mrd_cnt_nxt;
      busy_r <= busy_nxt;
      bl8_r <= bl8_nxt;
    end
  end

  // dll reset pulse and lock wait counter
  always_comb begin
    dll_rst_nxt = load_ok && addr_m[DLL_BIT];
    dll_cnt_nxt = dll_cnt_r;
    dll_rdy_nxt = dll_rdy_r;
    if (dll_rst_nxt) begin
      dll_cnt_nxt = 8'h00;
      dll_rdy_nxt = 1'b0;
    end else if (!dll_rdy_r && valid_r) begin
      dll_cnt_nxt = 8'(dll_cnt_r + 8'h01);
      dll_rdy_nxt = (dll_cnt_nxt == DLL_LOCK_CYC);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dll_rst_r <= 1'b0;
      dll_cnt_r <= 8'h00;
      dll_rdy_r <= 1'b0;
    end else begin
      dll_rst_r <= dll_rst_nxt;
      dll_cnt_r <= dll_cnt_nxt;
      dll_rdy_r <= dll_rdy_nxt;
    end
  end

  assign last_pair = len8_r ? (pair_r == LAST_PAIR_8) :
                              (pair_r == LAST_PAIR_4);

  // burst sequencing; length and order are frozen at the start of a burst
  // so a mode change can never reshape a burst already in flight
  always_comb begin
    state_nxt = state_r;
    start_nxt = start_r;
    pair_nxt = pair_r;
    len8_nxt = len8_r;
    il_nxt = il_r;
    ap_nxt = ap_r;
    err_nxt = 1'b0;
    ap_start = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if ((is_read || is_write) && valid_r && !busy_r) begin
          state_nxt = is_read ? ST_READ : ST_WRITE;
        end else if (is_read || is_write) begin
          err_nxt = 1'b1;
        end
      end
      ST_READ, ST_WRITE: begin
        if (!last_pair) begin
          pair_nxt = 2'(pair_r + 2'h1);
        end else begin
          state_nxt = ST_IDLE;
          ap_start = (state_r == ST_WRITE) && ap_r;
        end
        if ((is_read && state_r == ST_READ) ||
            (is_write && state_r == ST_WRITE)) begin
          // seamless at the last pair, cut short only in eight-beat mode
          if (last_pair || len8_r) begin
            state_nxt = state_r;
            ap_start = 1'b0;
          end else begin
            err_nxt = 1'b1;
          end
        end else if (is_read || is_write || is_load) begin
          err_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if ((is_read || is_write) && !err_nxt && state_nxt != ST_IDLE &&
        (state_r == ST_IDLE || state_nxt == state_r) &&
        (state_r == ST_IDLE || last_pair || len8_r)) begin
      start_nxt = addr_m[2:0];
      pair_nxt = 2'h0;
      len8_nxt = (mode_r[BL_LSB +: 3] == BL_CODE_8);
      il_nxt = mode_r[BT_BIT];
      ap_nxt = is_write && addr_m[AP_BIT];
    end
    if (is_load && !load_ok) begin
      err_nxt = 1'b1; // refused load, see bank and timing checks
    end
    active_nxt = (state_nxt != ST_IDLE);
    is_wr_nxt = (state_nxt == ST_WRITE);
  end

  // beat columns for the pair that the next clock will move
  burst_col_gen u_col (
    .start_col_i(start_nxt),
    .pair_i(pair_nxt),
    .len8_i(len8_nxt),
    .interleave_i(il_nxt),
    .col_a_o(col_a_c),
    .col_b_o(col_b_c)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      start_r <= 3'h0;
      pair_r <= 2'h0;
      len8_r <= 1'b0;
      il_r <= 1'b0;
      ap_r <= 1'b0;
      col_a_r <= 3'h0;
      col_b_r <= 3'h0;
      err_r <= 1'b0;
      active_r <= 1'b0;
      is_wr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      start_r <= start_nxt;
      pair_r <= pair_nxt;
      len8_r <= len8_nxt;
      il_r <= il_nxt;
      ap_r <= ap_nxt;
      col_a_r <= (state_nxt == ST_IDLE) ? 3'h0 : col_a_c;
      col_b_r <= (state_nxt == ST_IDLE) ? 3'h0 : col_b_c;
      err_r <= err_nxt;
      active_r <= active_nxt;
      is_wr_r <= is_wr_nxt;
    end
  end

  // write recovery in clocks plus the precharge period
  assign ap_cycles = 5'({1'b0, wr_cyc_r} + TRP_CYC_W);

  wr_recovery_timer u_wr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(ap_start),
    .cycles_i(ap_cycles),
    .busy_o(tmr_busy),
    .done_o(tmr_done)
  );

  // outputs straight from registers
  assign operating_mode_word_o = mode_r;
  assign mode_valid_o = valid_r;
  assign mode_busy_o = busy_r;
  assign burst_count_8_o = bl8_r;
  assign burst_order_select_o = mode_r[BT_BIT];
  // the code equals the latency in whole clocks, no half-clock step
  assign cas_latency_o = mode_r[CL_LSB +: 3];
  assign factory_test_bit_o = mode_r[TM_BIT];
  assign wr_cycles_o = wr_cyc_r;
  assign powerdown_exit_speed_o = mode_r[PD_BIT];
  assign mode_code_error_o = code_err_r;
  assign dll_reset_o = dll_rst_r;
  assign dll_ready_o = dll_rdy_r;
  assign burst_active_o = active_r;
  assign burst_is_write_o = is_wr_r;
  assign beat_col_a_o = col_a_r;
  assign beat_col_b_o = col_b_r;
  assign cmd_error_o = err_r;
  assign precharge_busy_o = tmr_busy;
  assign precharge_done_o = tmr_done;

endmodule
`default_nettype wire

// >>> tb/mode_word_checker_assertions.sv
// Purpose: port-level timing checks for the mode-word block
// Assumes: one clock, reset high and asynchronous
// Notes: acceptance terms are rebuilt here from the pins
`timescale 1ns/10ps
`default_nettype none
module mode_word_checker
  import mode_word_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [2:0] ba_i,
  input wire logic [13:0] addr_i,
  input wire logic all_banks_idle_i,
  input wire logic [13:0] operating_mode_word_o,
  input wire logic mode_valid_o,
  input wire logic mode_busy_o,
  input wire logic burst_count_8_o,
  input wire logic burst_order_select_o,
  input wire logic [2:0] cas_latency_o,
  input wire logic [3:0] wr_cycles_o,
  input wire logic dll_reset_o,
  input wire logic burst_active_o,
  input wire logic [2:0] beat_col_a_o,
  input wire logic [2:0] beat_col_b_o,
  input wire logic cmd_error_o
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [3:0] cmd;
  logic load_ok, rw_ok;
  logic [2:0] ca;
  // acceptance as the pins present it; bank state kept apart for refusals
  assign cmd = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
  assign load_ok = cke_i && cmd == CMD_LOAD && ba_i == BA_MODE
    && !burst_active_o && !mode_busy_o;
  assign rw_ok = cke_i && (cmd == CMD_READ || cmd == CMD_WRITE)
    && mode_valid_o && !mode_busy_o && !burst_active_o;
  assign ca = beat_col_a_o;
  sequence busy_two;
    mode_busy_o [*2] ##1 !mode_busy_o;
  endsequence
  a_load_busy_window: assert property (
    load_ok && all_banks_idle_i |=> busy_two) else $error("busy window");
  a_load_word_taken: assert property (
    load_ok && all_banks_idle_i |=> mode_valid_o
    && operating_mode_word_o == $past(addr_i)) else $error("word not taken");
  a_busy_bank_refused: assert property (
    load_ok && !all_banks_idle_i |=> cmd_error_o
    && $stable(operating_mode_word_o)) else $error("busy load not refused");
  a_dll_reset_pulse: assert property (
    load_ok && all_banks_idle_i |=> dll_reset_o == $past(addr_i[DLL_BIT])
    ##1 !dll_reset_o) else $error("dll reset pulse wrong");
  a_length_decode: assert property (
    mode_valid_o |-> burst_count_8_o ==
    (operating_mode_word_o[2:0] == BL_CODE_8)) else $error("length decode");
  a_order_follows: assert property (
    burst_order_select_o == operating_mode_word_o[BT_BIT])
    else $error("order field");
  a_latency_field: assert property (
    cas_latency_o == operating_mode_word_o[6:4]) else $error("latency");
  a_recovery_decode: assert property (
    mode_valid_o |-> wr_cycles_o == 4'(operating_mode_word_o[11:9]) + 4'h1)
    else $error("recovery decode");
  a_first_column: assert property (
    rw_ok |=> burst_active_o && ca == $past(addr_i[2:0]))
    else $error("first column");
  a_pair_columns: assert property (
    burst_active_o |-> beat_col_b_o == (burst_order_select_o ? ca ^ 3'h1
    : {ca[2], 2'(ca[1:0] + 2'h1)})) else $error("odd beat column");
  a_term_ignored: assert property (
    cke_i && cmd == CMD_TERM |=> !cmd_error_o) else $error("terminate");
endmodule
bind ddr2_mode_register_burst_order mode_word_checker u_mode_word_checker (
  .clk_i, .rst_i, .cke_i, .cs_n_i, .ras_n_i, .cas_n_i, .we_n_i, .ba_i,
  .addr_i, .all_banks_idle_i, .operating_mode_word_o, .mode_valid_o,
  .mode_busy_o, .burst_count_8_o, .burst_order_select_o, .cas_latency_o,
  .wr_cycles_o, .dll_reset_o, .burst_active_o, .beat_col_a_o,
  .beat_col_b_o, .cmd_error_o);
`default_nettype wire

// >>> tb/ddr2_ctrl_model.sv
// Purpose: command-pin model of the memory controller
// Assumes: callers sit on a rising edge when they call a task
// Notes: released pins show their inverse so stale values never match
`timescale 1ns/10ps
`default_nettype none
module ddr2_ctrl_model
  import mode_word_pkg::*;
(
  input wire logic clk_i,
  output logic cke_o,
  output logic [3:0] cmd_o,
  output logic [2:0] ba_o,
  output logic [13:0] addr_o,
  output logic idle_o
);
  // power-up: deselected, clock enabled, banks precharged
  initial begin
    cke_o = 1'b1;
    idle_o = 1'b1;
    cmd_o = 4'hF;
    ba_o = 3'h7;
    addr_o = 14'h0000;
  end
  // one command, sampled at the next edge; loads keep A7 and A13 low
  task automatic send(input logic [3:0] c, input logic [13:0] a,
      input logic [2:0] b);
    cmd_o <= c;
    ba_o <= b;
    addr_o <= (c == CMD_LOAD) ? (a & 14'h1F7F) : a;
    @(posedge clk_i);
  endtask
  // deselect, then spend n edges; used for the mode-set gap too
  task automatic nop(input int n);
    cmd_o <= 4'hF;
    ba_o <= ~ba_o;
    addr_o <= ~addr_o;
    repeat (n) @(posedge clk_i);
  endtask
  // clock enable and bank state as the block sees them
  task automatic set_pins(input logic k, input logic i);
    cke_o <= k;
    idle_o <= i;
  endtask
endmodule
`default_nettype wire

// >>> tb/ddr2_mode_register_burst_order_bench.sv
// Purpose: directed regression of mode loads and burst column order
// Assumes: pins come from the controller model at rising edges
// Notes: one deliberate reserved-code load reaches the error flag
`timescale 1ns/10ps
`default_nettype none
module ddr2_mode_register_burst_order_bench
  import mode_word_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cke_i, all_banks_idle_i, mode_valid_o, mode_busy_o, burst_count_8_o;
  logic burst_order_select_o, powerdown_exit_speed_o, dll_ready_o;
  logic burst_active_o, cmd_error_o, precharge_busy_o, precharge_done_o;
  logic factory_test_bit_o, mode_code_error_o, dll_reset_o, burst_is_write_o;
  logic busy_seen;
  logic [3:0] cmd, wr_cycles_o;
  logic [2:0] ba_i, cas_latency_o, beat_col_a_o, beat_col_b_o;
  logic [13:0] addr_i, operating_mode_word_o;
  int fails = 0;
  int compares = 0;
  int i;
  int dll_pulses = 0;
  always #10 clk_i = ~clk_i;
  // count dll reset pulses; each must last one clock, so edges count them
  always @(posedge clk_i) begin
    if (dll_reset_o === 1'b1) begin
      dll_pulses <= dll_pulses + 1;
    end
  end
  ddr2_ctrl_model u_ddr2_ctrl_model (.clk_i, .cke_o(cke_i), .cmd_o(cmd),
    .ba_o(ba_i), .addr_o(addr_i), .idle_o(all_banks_idle_i));
  ddr2_mode_register_burst_order u_ddr2_mode_register_burst_order (
    .clk_i, .rst_i, .cke_i, .cs_n_i(cmd[3]), .ras_n_i(cmd[2]),
    .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .ba_i, .addr_i, .all_banks_idle_i,
    .operating_mode_word_o, .mode_valid_o, .mode_busy_o, .burst_count_8_o,
    .burst_order_select_o, .cas_latency_o, .factory_test_bit_o,
    .wr_cycles_o, .powerdown_exit_speed_o, .mode_code_error_o,
    .dll_reset_o, .dll_ready_o, .burst_active_o, .burst_is_write_o,
    .beat_col_a_o, .beat_col_b_o, .cmd_error_o, .precharge_busy_o,
    .precharge_done_o);
  task automatic chk(input string n, input logic [13:0] e,
      input logic [13:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic print_verdict;
    if (fails == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // column of beat k from start s, worked out independently of the design
  function automatic logic [2:0] ecol(input logic [2:0] s, input int k,
      input logic il);
    logic [2:0] kk;
    kk = 3'(k);
    if (il) return s ^ kk;
    return {s[2] ^ kk[2], 2'(s[1:0] + kk[1:0])};
  endfunction
  // load waits out the mode-set gap before anything else goes out
  task automatic load(input logic [13:0] w);
    u_ddr2_ctrl_model.send(CMD_LOAD, w, BA_MODE);
    u_ddr2_ctrl_model.nop(int'(TMRD_CYC) + 1);
  endtask
  task automatic fields(input logic [13:0] w);
    load(w);
    chk("word", w, operating_mode_word_o);
    chk("len8", 14'(w[2:0] == BL_CODE_8), 14'(burst_count_8_o));
    chk("order", 14'(w[3]), 14'(burst_order_select_o));
    chk("cl", 14'(w[6:4]), 14'(cas_latency_o));
    chk("wr", 14'(w[11:9]) + 14'h1, 14'(wr_cycles_o));
    chk("pdx", 14'(w[12]), 14'(powerdown_exit_speed_o));
    chk("test_bit", 14'h0, 14'(factory_test_bit_o));
    chk("code_err", 14'h0, 14'(mode_code_error_o));
  endtask
  task automatic burst(input logic [3:0] c, input logic [13:0] a,
      input logic l8, input logic il);
    logic [2:0] ea;
    logic [2:0] eb;
    u_ddr2_ctrl_model.send(c, a, BA_MODE);
    u_ddr2_ctrl_model.nop(0);
    for (int p = 0; p < (l8 ? 4 : 2); p++) begin
      ea = ecol(a[2:0], 2 * p, il);
      eb = ecol(a[2:0], 2 * p + 1, il);
      #1;
      chk("col_a", 14'(ea), 14'(beat_col_a_o));
      chk("col_b", 14'(eb), 14'(beat_col_b_o));
      chk("is_wr", 14'(c == CMD_WRITE), 14'(burst_is_write_o));
      @(posedge clk_i);
    end
    #1;
    chk("len_end", 14'h0, 14'(burst_active_o));
    @(posedge clk_i);
  endtask
  // a second command one clock into a four-beat read
  task automatic pair(input logic [3:0] c, input logic e);
    u_ddr2_ctrl_model.send(CMD_READ, 14'h0000, BA_MODE);
    u_ddr2_ctrl_model.send(c, 14'h0000, BA_MODE);
    u_ddr2_ctrl_model.nop(0);
    #1;
    chk("refused", 14'(e), 14'(cmd_error_o));
    chk("active", 14'h1, 14'(burst_active_o));
    repeat (3) @(posedge clk_i);
  endtask
  initial begin
    busy_seen = 1'b0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // recovery code 1 gives two clocks, the rounded-up recovery time here
    fields(14'h0332);
    chk("dll_pulse", 14'h1, 14'(dll_pulses));
    i = 0;
    // reads only once the DLL has had its lock time
    while (dll_ready_o !== 1'b1 && i < 300) begin
      @(posedge clk_i);
      i++;
    end
    chk("dll_ready", 14'h1, 14'(dll_ready_o));
    if (dll_ready_o !== 1'b1) print_verdict();
    // every order and length, latencies 3 to 7, recovery 4 to 8
    for (int m = 0; m < 5; m++) begin
      fields({1'b0, m[0], 3'(m + 3), 2'h0, 3'(m + 3), m[1],
        m[0] ? BL_CODE_8 : BL_CODE_4});
      burst(CMD_READ, 14'(3 * m + 1), m[0], m[1]);
      burst(CMD_WRITE, 14'(5 * m + 2), m[0], m[1]);
    end
    // reads one burst apart must stream with no idle clock
    u_ddr2_ctrl_model.send(CMD_READ, 14'h0001, BA_MODE);
    u_ddr2_ctrl_model.nop(1);
    u_ddr2_ctrl_model.send(CMD_READ, 14'h0006, BA_MODE);
    u_ddr2_ctrl_model.nop(0);
    #1;
    chk("seam_col", 14'h6, 14'(beat_col_a_o));
    chk("seam_act", 14'h1, 14'(burst_active_o));
    repeat (3) @(posedge clk_i);
    pair(CMD_WRITE, 1'b1);
    pair(CMD_TERM, 1'b0);
    pair(CMD_LOAD, 1'b1);
    // loads that must leave the stored word alone
    u_ddr2_ctrl_model.set_pins(1'b1, 1'b0);
    load(14'h0233);
    chk("banks_open", 14'h0E72, operating_mode_word_o);
    u_ddr2_ctrl_model.set_pins(1'b0, 1'b1);
    load(14'h0233);
    chk("cke_low", 14'h0E72, operating_mode_word_o);
    u_ddr2_ctrl_model.set_pins(1'b1, 1'b1);
    u_ddr2_ctrl_model.send(CMD_LOAD, 14'h0233, 3'h1);
    u_ddr2_ctrl_model.nop(3);
    chk("bank_sel", 14'h0E72, operating_mode_word_o);
    // auto-precharge write: recovery plus precharge before done
    u_ddr2_ctrl_model.send(CMD_WRITE, 14'h0400, BA_MODE);
    u_ddr2_ctrl_model.nop(0);
    i = 0;
    while (precharge_done_o !== 1'b1 && i < 40) begin
      @(posedge clk_i);
      #1;
      busy_seen = busy_seen | precharge_busy_o;
      i++;
    end
    chk("ap_done", 14'h1, 14'(precharge_done_o));
    chk("ap_busy", 14'h1, 14'(busy_seen));
    // two pairs of the four-beat write, then recovery code 7 (eight clocks)
    // and the precharge period before the done pulse shows
    chk("ap_early", 14'(2 + 8 + TRP_CYC), 14'(i));
    // reserved length and latency codes, outside the controller's rules
    load(14'h0E00);
    chk("code_err", 14'h1, 14'(mode_code_error_o));
    chk("dll_pulses", 14'h1, 14'(dll_pulses));
    print_verdict();
  end
endmodule
`default_nettype wire
